// ### rtl/pmic_seq_pkg.sv
package pmic_seq_pkg;

	// ****************************************
	// Sizes and clock
	// ****************************************
	localparam int NUM_CH = 8;
	localparam int NUM_GRP = 5;
	localparam int CLK_HZ = 10000000;
	localparam int FRAME_BITS = 14;

	// ****************************************
	// Timing
	// ****************************************
	// Soft over-current limit time and short-circuit retry time in ms
	localparam int OC_LIMIT_MS = 10;
	localparam int RETRY_MS = 10;
	// Button hold threshold unit as a left shift of ms ticks (16 ticks)
	localparam int HOLD_UNIT_SHIFT = 4;

	// ****************************************
	// Command addresses
	// ****************************************
	localparam logic [4:0] ADDR_GROUP = 5'h00;
	localparam logic [4:0] ADDR_CONFIG = 5'h01;
	localparam logic [4:0] ADDR_SOFT_START = 5'h02;
	localparam logic [4:0] ADDR_SECONDARY = 5'h03;
	localparam logic [4:0] ADDR_HOLD = 5'h04;
	localparam logic [4:0] ADDR_SUMMARY = 5'h05;
	localparam logic [4:0] ADDR_STATUS = 5'h06;
	localparam logic [4:0] ADDR_FAULT_BASE = 5'h08;
	localparam logic [4:0] ADDR_DAC_BASE = 5'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int GRP_GATE_OUT = 0;
	localparam int GRP_MAIN_SUPPLY = 1;
	localparam int GRP_AUX = 2;
	localparam int GRP_BACKLIGHT = 3;
	localparam int GRP_ALT_SEQUENCE = 4;
	localparam int GLOBAL_OFF_BIT = 7;
	localparam int CFG_RESPONSE_B = 0;
	localparam int CFG_ALT_SEQ = 1;
	localparam int CFG_ACCURATE = 2;
	localparam int FT_THERMAL = 0;
	localparam int FT_OVER_CURRENT = 1;
	localparam int FT_SHORT = 2;
	localparam int FT_OVER_VOLT = 3;
	localparam int FT_UNDER_VOLT = 4;
	localparam int CH_IO = 4;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [7:0] GROUP_RST = 8'h02;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] HOLD_RST = 8'h40;
	localparam logic [7:0] DAC_RST = 8'h80;
	localparam logic [1:0] SECONDARY_RST = 2'h1;
	localparam logic [7:0] THERMAL_PRESENT = 8'hbf;

	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_BOOT = 6'h02,
		ST_SAMPLE = 6'h04,
		ST_RAMP = 6'h08,
		ST_RUN = 6'h10,
		ST_DOWN = 6'h20
	} seq_state_e;

endpackage

// ### rtl/pmic_seq_fault_ctrl.sv
// Function
// - A thermal trip shuts every regulator of the tripping regulator's group.
// - A thermal trip in the main supply group shuts the whole chip.
// - Soft over-current limits cycle by cycle; still limited after 10 ms shuts off.
// - A short-circuit turns the affected output off at once.
// - After a short, only the main group retries once after 10 ms.
// - Selectable voltage response A: output off and fault flagged.
// - Response B: output stays on, fault flagged, host decides.
// - Gate supply boots in peak detect; reference good releases power-on reset.
// - At reset release sample rate and soft-start pins, ramp main group.
// - Group commands are accepted only after the main supplies are up.
// - Alternate sequence moves the I/O regulator under separate host ordering.
// - Sampled soft-start is default; channels five to eight reprogrammable afterwards.
// - Channels one to five use the primary clock in four staggered phases.
// - Channels six to eight use a host programmable secondary clock.
// - Summary fault register plus per channel fault type registers.
// - Standard mode executes each command once fully received.
// - Accurate mode executes only when two consecutive copies match.
// - Five groups: gate out, main, aux, backlight, alternate.
// - Alternate group holds the I/O regulator only with option one.
// - A group switches all its regulators together.
// - Gate supply hands over to PWM once alive and rate selected.
// - Each regulator has a host written reference code.
// - Global off command shuts down the whole chip.
// - Button press and release turns on; long hold turns off.
`timescale 1ns/1ps
module pmic_seq_fault_ctrl import pmic_seq_pkg::*; #(
	parameter int MS_CYCLES = CLK_HZ / 1000
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic ref_rail_good_i,
	input wire logic main_good_i,
	input wire logic [2:0] select_pin_a_i,
	input wire logic [1:0] soft_start_sel_i,
	input wire logic power_button_pin_i,
	input wire logic link_clk_i,
	input wire logic link_data_i,
	input wire logic link_sel_n_i,
	input wire logic [7:0] thermal_i,
	input wire logic [7:0] soft_oc_i,
	input wire logic [7:0] short_i,
	input wire logic [7:0] over_volt_i,
	input wire logic [7:0] under_volt_i,
	output logic chip_on_o,
	output logic por_released_o,
	output logic gate_pwm_o,
	output logic [7:0] reg_enable_o,
	output logic [7:0] current_limit_o,
	output logic [3:0] primary_phase_o,
	output logic secondary_switch_clock_o,
	output logic [15:0] soft_start_code_o,
	output logic [63:0] dac_code_o,
	output logic [7:0] fault_summary_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NA = 46;
	localparam int MSW = $clog2(MS_CYCLES + 1);
	logic [NA-1:0] async_in;
	logic [NA-1:0] s1;
	logic [NA-1:0] s2;
	logic [NA-1:0] s3;
	logic [NA-1:0] st;
	assign async_in = {ref_rail_good_i, main_good_i, power_button_pin_i, link_clk_i,
		link_data_i, link_sel_n_i, thermal_i, soft_oc_i, short_i, over_volt_i, under_volt_i};

	// Three stages per bit; a change counts when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NA; gi++) begin : g_sync
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					s1[gi] <= (gi == 40); // Select idles high
					s2[gi] <= (gi == 40);
					s3[gi] <= (gi == 40);
					st[gi] <= (gi == 40);
				end else begin
					s1[gi] <= async_in[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi])
						st[gi] <= s3[gi];
				end
			end
		end
	endgenerate

	logic ref_good;
	logic main_good;
	logic button;
	logic lclk;
	logic ldata;
	logic lsel_n;
	logic [7:0] hot;
	logic [7:0] soft_oc;
	logic [7:0] shorted;
	logic [7:0] ovolt;
	logic [7:0] uvolt;
	assign {ref_good, main_good, button, lclk, ldata, lsel_n} = st[45:40];
	assign hot = st[39:32] & THERMAL_PRESENT;
	assign {soft_oc, shorted, ovolt, uvolt} = st[31:0];

	// ****************************************
	// Declarations
	// ****************************************
	seq_state_e state;
	logic [7:0] group_en;
	logic [7:0] config_r;
	logic [7:0] ss_prog;
	logic [1:0] ss_default;
	logic [2:0] rate_sel;
	logic [1:0] secondary_sel;
	logic [7:0] hold_sel;
	logic [7:0] dac [NUM_CH];
	logic [4:0] fault_type [NUM_CH];
	logic [7:0] kill;
	logic [7:0] oc_expired;
	logic [7:0] same_hot;
	logic [7:0] main_mask;
	logic [7:0] group_on;
	logic [7:0] next_enable;
	logic main_hot;
	logic chip_kill;
	logic global_off;
	logic long_hold;
	logic short_release;
	logic running;
	logic active;
	logic [MSW-1:0] ms_cnt;
	logic ms_tick;

	assign running = (state == ST_RUN);
	assign active = (state == ST_RAMP) || running;

	// Group index of a channel; the I/O regulator moves with the alternate option
	function automatic int group_of(input int ch, input logic alt);
		int g;
		g = GRP_BACKLIGHT;
		if (ch == 0)
			g = GRP_GATE_OUT;
		else if (ch <= 3)
			g = GRP_MAIN_SUPPLY;
		else if (ch == CH_IO)
			g = alt ? GRP_ALT_SEQUENCE : GRP_AUX;
		else if (ch <= 6)
			g = GRP_AUX;
		return g;
	endfunction

	// ****************************************
	// Group membership and thermal spread
	// ****************************************
	// group map
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			group_on[c] = group_en[group_of(c, config_r[CFG_ALT_SEQ])];
			main_mask[c] = (group_of(c, config_r[CFG_ALT_SEQ]) == GRP_MAIN_SUPPLY);
			same_hot[c] = 1'b0;
			for (int k = 0; k < NUM_CH; k++)
				if (group_of(k, config_r[CFG_ALT_SEQ]) == group_of(c, config_r[CFG_ALT_SEQ]))
					same_hot[c] = same_hot[c] | hot[k];
		end
	end

	// main group thermal kills the chip
	assign main_hot = |(hot & main_mask);
	assign chip_kill = main_hot | global_off | (running & long_hold);

	// ****************************************
	// Millisecond tick
	// ****************************************
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ms_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_cnt == MSW'(MS_CYCLES - 1));
			ms_cnt <= (ms_cnt == MSW'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
		end
	end

	// ****************************************
	// Power sequencer
	// ****************************************
	// boot, reset release, ramp
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_BOOT;
		end else begin
			case (state)
				ST_OFF: if (short_release) state <= ST_BOOT;
				ST_BOOT: if (ref_good) state <= ST_SAMPLE;
				ST_SAMPLE: state <= ST_RAMP;
				ST_RAMP: if (chip_kill) state <= ST_DOWN;
					else if (main_good) state <= ST_RUN;
				ST_RUN: if (chip_kill) state <= ST_DOWN;
				ST_DOWN: state <= ST_OFF;
				default: state <= ST_OFF;
			endcase
		end
	end

	// Straps caught once at reset release of the sequencer
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rate_sel <= '0;
			ss_default <= '0;
		end else if (state == ST_SAMPLE) begin
			rate_sel <= select_pin_a_i;
			ss_default <= soft_start_sel_i;
		end
	end

	// ****************************************
	// Power button
	// ****************************************
	logic btn_prev;
	logic [11:0] hold_cnt;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			btn_prev <= 1'b0;
			hold_cnt <= '0;
		end else begin
			btn_prev <= button;
			if (!button)
				hold_cnt <= '0;
			else if (ms_tick && hold_cnt != 12'hfff)
				hold_cnt <= hold_cnt + 1'b1;
		end
	end
	assign long_hold = button && (hold_cnt == {hold_sel, HOLD_UNIT_SHIFT'(0)});
	assign short_release = btn_prev && !button && (hold_cnt < {hold_sel, HOLD_UNIT_SHIFT'(0)});

	// ****************************************
	// Serial link receiver
	// ****************************************
	logic lclk_prev;
	logic lsel_prev;
	logic [FRAME_BITS-1:0] shift;
	logic [3:0] bit_cnt;
	logic frame_done;
	logic [FRAME_BITS-1:0] first_copy;
	logic have_first;
	logic exec;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lclk_prev <= 1'b0;
			lsel_prev <= 1'b1;
			shift <= '0;
			bit_cnt <= '0;
			frame_done <= 1'b0;
		end else begin
			lclk_prev <= lclk;
			lsel_prev <= lsel_n;
			frame_done <= lsel_n && !lsel_prev && (bit_cnt == 4'(FRAME_BITS));
			if (lsel_n && lsel_prev)
				bit_cnt <= '0;
			else if (!lsel_n && lclk && !lclk_prev) begin
				shift <= {shift[FRAME_BITS-2:0], ldata};
				if (bit_cnt != 4'hf)
					bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

	// accurate mode needs two matching copies
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			first_copy <= '0;
			have_first <= 1'b0;
		end else if (frame_done && config_r[CFG_ACCURATE]) begin
			if (have_first && first_copy == shift)
				have_first <= 1'b0;
			else begin
				first_copy <= shift;
				have_first <= 1'b1;
			end
		end else if (!config_r[CFG_ACCURATE])
			have_first <= 1'b0;
	end
	assign exec = frame_done && (!config_r[CFG_ACCURATE] || (have_first && first_copy == shift));

	logic cmd_wr;
	logic [4:0] cmd_addr;
	logic [7:0] cmd_data;
	assign cmd_wr = shift[13];
	assign cmd_addr = shift[12:8];
	assign cmd_data = shift[7:0];
	assign global_off = exec && cmd_wr && cmd_addr == ADDR_GROUP && cmd_data[GLOBAL_OFF_BIT];

	// ****************************************
	// Control registers
	// ****************************************
	// main group only after reset
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_en <= GROUP_RST;
		end else if (state == ST_DOWN) begin
			group_en <= GROUP_RST;
		end else if (running && exec && cmd_wr && cmd_addr == ADDR_GROUP) begin
			group_en <= {3'h0, cmd_data[4:2], group_en[GRP_MAIN_SUPPLY], cmd_data[0]};
		end
	end

	// secondary clock reprogram after power up
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			config_r <= CONFIG_RST;
			ss_prog <= '0;
			secondary_sel <= SECONDARY_RST;
			hold_sel <= HOLD_RST;
		end else begin
			if (state == ST_SAMPLE)
				ss_prog <= {4{soft_start_sel_i}};
			if (exec && cmd_wr) begin
				if (cmd_addr == ADDR_CONFIG)
					config_r <= cmd_data;
				if (cmd_addr == ADDR_HOLD)
					hold_sel <= cmd_data;
				if (running && cmd_addr == ADDR_SOFT_START)
					ss_prog <= cmd_data;
				if (running && cmd_addr == ADDR_SECONDARY)
					secondary_sel <= cmd_data[1:0];
			end
		end
	end

	// ****************************************
	// Per channel protection
	// ****************************************
	logic retry_used;
	logic retry_wait;
	logic [3:0] retry_cnt;
	logic retry_fire;
	logic main_short;
	assign main_short = |(shorted & main_mask & group_on);

	// single main group retry after 10 ms
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			retry_used <= 1'b0;
			retry_wait <= 1'b0;
			retry_cnt <= '0;
			retry_fire <= 1'b0;
		end else begin
			retry_fire <= 1'b0;
			if (state == ST_OFF) begin
				retry_used <= 1'b0;
				retry_wait <= 1'b0;
			end else if (retry_wait) begin
				if (ms_tick)
					retry_cnt <= retry_cnt + 1'b1;
				if (retry_cnt == 4'(RETRY_MS)) begin
					retry_wait <= 1'b0;
					retry_fire <= 1'b1;
				end
			end else if (main_short && !retry_used) begin
				retry_wait <= 1'b1;
				retry_used <= 1'b1;
				retry_cnt <= '0;
			end
		end
	end

	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			logic [3:0] oc_ms;
			logic reopen;
			assign reopen = (state == ST_OFF) || (retry_fire && main_mask[gi]) ||
				(running && exec && cmd_wr && cmd_addr == ADDR_GROUP &&
				cmd_data[group_of(gi, config_r[CFG_ALT_SEQ])]);

			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					oc_ms <= '0;
					oc_expired[gi] <= 1'b0;
				end else begin
					oc_expired[gi] <= soft_oc[gi] && !kill[gi] && oc_ms == 4'(OC_LIMIT_MS);
					if (!soft_oc[gi] || kill[gi])
						oc_ms <= '0;
					else if (ms_tick && oc_ms != 4'(OC_LIMIT_MS))
						oc_ms <= oc_ms + 1'b1;
				end
			end

			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i)
					kill[gi] <= 1'b0;
				else if (shorted[gi] || oc_expired[gi] || same_hot[gi] ||
					((ovolt[gi] || uvolt[gi]) && !config_r[CFG_RESPONSE_B]))
					kill[gi] <= 1'b1;
				else if (reopen)
					kill[gi] <= 1'b0;
			end

			// sticky flags; a new fault beats the read clear
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i)
					fault_type[gi] <= '0;
				else if (exec && !cmd_wr && cmd_addr == ADDR_FAULT_BASE + 5'(gi))
					fault_type[gi] <= {uvolt[gi], ovolt[gi], shorted[gi], oc_expired[gi], hot[gi]};
				else
					fault_type[gi] <= fault_type[gi] |
						{uvolt[gi], ovolt[gi], shorted[gi], oc_expired[gi], hot[gi]};
			end

			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i)
					dac[gi] <= DAC_RST;
				else if (exec && cmd_wr && cmd_addr == ADDR_DAC_BASE + 5'(gi))
					dac[gi] <= cmd_data;
			end
			assign dac_code_o[gi*8 +: 8] = dac[gi];
		end
	endgenerate

	always_comb begin
		next_enable = '0;
		if (active)
			next_enable = group_on & ~kill;
	end

	// ****************************************
	// Outputs and read-back
	// ****************************************
	// summary and type read-back
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chip_on_o <= 1'b0;
			por_released_o <= 1'b0;
			gate_pwm_o <= 1'b0;
			reg_enable_o <= '0;
			current_limit_o <= '0;
			soft_start_code_o <= '0;
			fault_summary_o <= '0;
			rd_data_o <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			chip_on_o <= (state != ST_OFF) && (state != ST_DOWN);
			por_released_o <= (state == ST_SAMPLE) || active;
			gate_pwm_o <= active;
			reg_enable_o <= next_enable;
			current_limit_o <= soft_oc & next_enable;
			soft_start_code_o <= {ss_prog, {4{ss_default}}};
			for (int c = 0; c < NUM_CH; c++)
				fault_summary_o[c] <= |fault_type[c];
			rd_valid_o <= exec && !cmd_wr;
			if (exec && !cmd_wr) begin
				rd_data_o <= '0;
				case (cmd_addr)
					ADDR_GROUP: rd_data_o <= group_en;
					ADDR_CONFIG: rd_data_o <= config_r;
					ADDR_SOFT_START: rd_data_o <= ss_prog;
					ADDR_SECONDARY: rd_data_o <= {6'h00, secondary_sel};
					ADDR_HOLD: rd_data_o <= hold_sel;
					ADDR_SUMMARY: rd_data_o <= fault_summary_o;
					ADDR_STATUS: rd_data_o <= {2'h0, state};
					default: begin
						if (cmd_addr >= ADDR_DAC_BASE)
							rd_data_o <= dac[cmd_addr[2:0]];
						else if (cmd_addr >= ADDR_FAULT_BASE)
							rd_data_o <= {3'h0, fault_type[cmd_addr[2:0]]};
					end
				endcase
			end
		end
	end

	// ****************************************
	// Switching clocks
	// ****************************************
	logic [2:0] qtr_cnt;
	logic [1:0] phase_idx;
	logic [4:0] sec_cnt;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qtr_cnt <= '0;
			phase_idx <= '0;
			primary_phase_o <= '0;
		end else begin
			primary_phase_o <= '0;
			if (active) begin
				qtr_cnt <= (qtr_cnt == rate_sel) ? '0 : qtr_cnt + 1'b1;
				if (qtr_cnt == rate_sel) begin
					phase_idx <= phase_idx + 1'b1;
					primary_phase_o[phase_idx] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sec_cnt <= '0;
			secondary_switch_clock_o <= 1'b0;
		end else if (active) begin
			sec_cnt <= (sec_cnt == {secondary_sel, 3'h7}) ? '0 : sec_cnt + 1'b1;
			if (sec_cnt == {secondary_sel, 3'h7})
				secondary_switch_clock_o <= !secondary_switch_clock_o;
		end else
			secondary_switch_clock_o <= 1'b0;
	end

endmodule

// ### sim/pmic_seq_fault_ctrl_props.sv
`timescale 1ns/1ps
module pmic_seq_fault_ctrl_props (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [7:0] thermal_i,
	input wire logic [7:0] short_i,
	input wire logic chip_on_o,
	input wire logic por_released_o,
	input wire logic gate_pwm_o,
	input wire logic [7:0] reg_enable_o,
	input wire logic [7:0] current_limit_o,
	input wire logic [3:0] primary_phase_o,
	input wire logic secondary_switch_clock_o,
	input wire logic [7:0] fault_summary_o,
	input wire logic rd_valid_o
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	chk_pwm_after_por: assert property (gate_pwm_o |-> por_released_o)
		else $error("pwm mode before reset release");
	chk_por_chip_on: assert property (por_released_o |-> chip_on_o)
		else $error("reset released while chip off");
	chk_enable_after_por: assert property ((reg_enable_o != 8'h00) |-> por_released_o || $past(por_released_o))
		else $error("regulator enabled before reset release");
	chk_limit_enabled: assert property ((current_limit_o & ~reg_enable_o & ~$past(reg_enable_o)) == 8'h00)
		else $error("limit on a disabled channel");
	chk_main_thermal: assert property ((|thermal_i[3:1]) [*8] |-> !chip_on_o)
		else $error("chip alive after main thermal trip");
	chk_rd_one_cycle: assert property (rd_valid_o |=> !rd_valid_o)
		else $error("read valid longer than one cycle");
	chk_flag_sticky: assert property (por_released_o && (|($past(fault_summary_o) & ~fault_summary_o)) |-> (rd_valid_o || $past(rd_valid_o) || $past(rd_valid_o, 2)) or (##1 rd_valid_o))
		else $error("fault flag dropped without read");
	chk_phase_rotate: assert property (primary_phase_o[0] |-> ##[1:8] (primary_phase_o[1] || !gate_pwm_o))
		else $error("phase one missing after phase zero");
	chk_phase_single: assert property ($onehot0(primary_phase_o))
		else $error("two phases at once");
	chk_secondary_idle: assert property (!gate_pwm_o && !$past(gate_pwm_o) |-> !secondary_switch_clock_o)
		else $error("secondary clock outside run");
	// Short channels other than the retrying main group stay off
	for (genvar c = 0; c < 8; c++) begin : g_short
		chk_short_off: assert property (short_i[c] [*7] |-> !reg_enable_o[c] || c inside {1, 2, 3})
			else $error("channel enabled during short");
	end
	cover property (rd_valid_o);
	cover property (|current_limit_o);
	cover property ($fell(chip_on_o));
endmodule

// ### sim/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
	output logic link_clk_o,
	output logic link_data_o,
	output logic link_sel_n_o
);
	// Idle link: clock still, not selected
	initial begin
		link_clk_o = 1'b0;
		link_data_o = 1'b0;
		link_sel_n_o = 1'b1;
	end
	// one whole 14 bit word per frame, MSB first
	task automatic send(input logic [13:0] w);
		link_sel_n_o = 1'b0;
		#400;
		for (int i = 13; i >= 0; i--) begin
			link_data_o = w[i];
			#400 link_clk_o = 1'b1;
			#400 link_clk_o = 1'b0;
		end
		#400 link_sel_n_o = 1'b1;
		// Released data line shows no stale value
		link_data_o = ~link_data_o;
	endtask
endmodule

// ### sim/pmic_sequencing_fault_control_bench.sv
`timescale 1ns/1ps
module pmic_sequencing_fault_control_bench import pmic_seq_pkg::*; ;
	logic clock_i = 1'b0;
	logic resetn_i, ref_rail_good_i, main_good_i, power_button_pin_i;
	logic [2:0] select_pin_a_i;
	logic [1:0] soft_start_sel_i;
	logic [7:0] thermal_i, soft_oc_i, short_i, over_volt_i, under_volt_i;
	logic link_clk, link_data, link_sel_n;
	logic chip_on_o, por_released_o, gate_pwm_o, secondary_switch_clock_o, rd_valid_o;
	logic [7:0] reg_enable_o, current_limit_o, fault_summary_o, rd_data_o;
	logic [3:0] primary_phase_o;
	logic [15:0] soft_start_code_o;
	logic [63:0] dac_code_o;
	int n_fail = 0;
	int n_tests = 0;

	// ****************************************
	// Clock, design and host
	// ****************************************
	always #50 clock_i = ~clock_i;
	pmic_seq_fault_ctrl #(.MS_CYCLES(10)) dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
		.ref_rail_good_i(ref_rail_good_i), .main_good_i(main_good_i),
		.select_pin_a_i(select_pin_a_i), .soft_start_sel_i(soft_start_sel_i),
		.power_button_pin_i(power_button_pin_i), .link_clk_i(link_clk),
		.link_data_i(link_data), .link_sel_n_i(link_sel_n), .thermal_i(thermal_i),
		.soft_oc_i(soft_oc_i), .short_i(short_i), .over_volt_i(over_volt_i),
		.under_volt_i(under_volt_i), .chip_on_o(chip_on_o), .por_released_o(por_released_o),
		.gate_pwm_o(gate_pwm_o), .reg_enable_o(reg_enable_o), .current_limit_o(current_limit_o),
		.primary_phase_o(primary_phase_o), .secondary_switch_clock_o(secondary_switch_clock_o),
		.soft_start_code_o(soft_start_code_o), .dac_code_o(dac_code_o),
		.fault_summary_o(fault_summary_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
	link_host_model host_u (.link_clk_o(link_clk), .link_data_o(link_data),
		.link_sel_n_o(link_sel_n));

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wait_clk(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		host_u.send({1'b1, a, d});
		wait_clk(12);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] exp, input string name);
		int i;
		host_u.send({1'b0, a, 8'h00});
		for (i = 0; i < 20 && rd_valid_o !== 1'b1; i++) begin
			@(negedge clock_i);
		end
		check("read valid", 8'h01, {7'h0, rd_valid_o});
		check(name, exp, rd_data_o);
		wait_clk(2);
	endtask
	task test_done;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_boot;
		check("reset enable", 8'h00, reg_enable_o);
		check("reset dac", 8'h80, dac_code_o[7:0]);
		ref_rail_good_i = 1'b1;
		wait_clk(10);
		check("por", 8'h01, {7'h0, por_released_o});
		check("pwm", 8'h01, {7'h0, gate_pwm_o});
		check("main enable", 8'h0e, reg_enable_o);
		check("soft start", 8'haa, soft_start_code_o[7:0]);
		rd(ADDR_GROUP, 8'h02, "group reset");
	endtask
	task t_groups;
		wr(ADDR_GROUP, 8'h0d);
		check("early group", 8'h0e, reg_enable_o);
		main_good_i = 1'b1;
		wait_clk(10);
		wr(ADDR_GROUP, 8'h0d);
		check("groups on", 8'hff, reg_enable_o);
		wr(ADDR_SOFT_START, 8'h1b);
		check("soft start prog", 8'h1b, soft_start_code_o[15:8]);
	endtask
	task t_clocks;
		int i;
		logic v;
		wr(ADDR_CONFIG, 8'h02);
		check("alt group", 8'hef, reg_enable_o);
		wr(ADDR_CONFIG, 8'h00);
		for (i = 0; i < 20 && primary_phase_o[0] !== 1'b1; i++)
			@(negedge clock_i);
		wait_clk(3);
		check("phase one", 8'h02, {4'h0, primary_phase_o});
		wait_clk(3);
		check("phase two", 8'h04, {4'h0, primary_phase_o});
		wr(ADDR_SECONDARY, 8'h00);
		v = secondary_switch_clock_o;
		for (i = 0; i < 40 && secondary_switch_clock_o === v; i++)
			@(negedge clock_i);
		wait_clk(4);
		check("secondary hold", {7'h0, ~v}, {7'h0, secondary_switch_clock_o});
		wait_clk(4);
		check("secondary toggle", {7'h0, v}, {7'h0, secondary_switch_clock_o});
	endtask
	task t_faults;
		thermal_i[5] = 1'b1;
		wait_clk(10);
		check("thermal group", 8'h8f, reg_enable_o);
		thermal_i[5] = 1'b0;
		wait_clk(10);
		check("sticky summary", 8'h20, fault_summary_o);
		rd(ADDR_FAULT_BASE + 5'h05, 8'h01, "thermal type");
		check("summary cleared", 8'h00, fault_summary_o);
		soft_oc_i[1] = 1'b1;
		wait_clk(10);
		check("limit", 8'h02, current_limit_o);
		soft_oc_i[1] = 1'b0;
		short_i[7] = 1'b1;
		wait_clk(10);
		check("short off", 8'h0f, reg_enable_o);
		short_i[7] = 1'b0;
		rd(ADDR_FAULT_BASE + 5'h07, 8'h04, "short type");
		short_i[1] = 1'b1;
		wait_clk(10);
		check("main short off", 8'h0d, reg_enable_o);
		short_i[1] = 1'b0;
		wait_clk(120);
		check("main retry", 8'h0f, reg_enable_o);
		rd(ADDR_FAULT_BASE + 5'h01, 8'h04, "main short type");
	endtask
	task t_volt;
		wr(ADDR_CONFIG, 8'h01);
		over_volt_i[0] = 1'b1;
		wait_clk(10);
		check("response b on", 8'h0f, reg_enable_o);
		check("response b flag", 8'h01, fault_summary_o);
		over_volt_i[0] = 1'b0;
		wr(ADDR_CONFIG, 8'h00);
		under_volt_i[0] = 1'b1;
		wait_clk(10);
		check("response a off", 8'h0e, reg_enable_o);
		under_volt_i[0] = 1'b0;
		rd(ADDR_FAULT_BASE, 8'h18, "volt type");
	endtask
	task t_link;
		wr(ADDR_DAC_BASE, 8'h33);
		check("dac standard", 8'h33, dac_code_o[7:0]);
		wr(ADDR_CONFIG, 8'h04);
		wr(ADDR_DAC_BASE + 5'h01, 8'h55);
		check("dac one copy", 8'h80, dac_code_o[15:8]);
		wr(ADDR_DAC_BASE + 5'h01, 8'h55);
		check("dac two copies", 8'h55, dac_code_o[15:8]);
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_CONFIG, 8'h00);
	endtask
	task t_off;
		thermal_i[2] = 1'b1;
		wait_clk(12);
		check("main thermal", 8'h00, {7'h0, chip_on_o});
		thermal_i[2] = 1'b0;
		power_button_pin_i = 1'b1;
		wait_clk(10);
		power_button_pin_i = 1'b0;
		wait_clk(20);
		check("button on", 8'h01, {7'h0, por_released_o});
		wr(ADDR_GROUP, 8'h80);
		wait_clk(10);
		check("global off", 8'h00, {7'h0, chip_on_o});
	endtask

	// Main sequence
	initial begin
		resetn_i = 1'b0;
		ref_rail_good_i = 1'b0;
		main_good_i = 1'b0;
		power_button_pin_i = 1'b0;
		select_pin_a_i = 3'h2;
		soft_start_sel_i = 2'h2;
		thermal_i = 8'h00;
		soft_oc_i = 8'h00;
		short_i = 8'h00;
		over_volt_i = 8'h00;
		under_volt_i = 8'h00;
		wait_clk(8);
		resetn_i = 1'b1;
		wait_clk(2);
		t_boot();
		t_groups();
		t_clocks();
		t_faults();
		t_volt();
		t_link();
		t_off();
		test_done();
	end
	// Watchdog against a hung run
	initial begin
		#2000000;
		n_fail++;
		test_done();
	end
endmodule

bind pmic_seq_fault_ctrl pmic_seq_fault_ctrl_props props_u (.clock_i(clock_i),
	.resetn_i(resetn_i), .thermal_i(thermal_i), .short_i(short_i), .chip_on_o(chip_on_o),
	.por_released_o(por_released_o), .gate_pwm_o(gate_pwm_o), .reg_enable_o(reg_enable_o),
	.current_limit_o(current_limit_o), .primary_phase_o(primary_phase_o),
	.secondary_switch_clock_o(secondary_switch_clock_o),
	.fault_summary_o(fault_summary_o), .rd_valid_o(rd_valid_o));
